// File: pbl_port.sv
// pbl_port.sv - device end of the three-state parallel host bus.
// assumes: pins are asynchronous to mclk_i; result and channel come from
// core logic on mclk_i; a pad ring resolves pin level from the enables.
`include "pbl_cfg.svh"

// Contract
// - lines 0-7 bidirectional, under select and strobes
// - word mode: shared pin is data bit 8
// - byte mode: shared pin is high_byte_enable input
// - byte, enable low: low eight bits on 0-7
// - byte, enable high: upper four bits on 0-3
// - high-byte read: channel tag on lines 4-6
// - word mode: lines 9-11 carry upper bits
// - drive result after read strobe with select
module pbl_port
  import pbl_pkg::*;
(
  // clock and reset
  input  wire logic                   mclk_i,
  input  wire logic                   rst_n_i,
  // host control pins
  input  wire logic                   cs_n_i,
  input  wire logic                   rd_n_i,
  input  wire logic                   wr_n_i,
  input  wire logic                   word_sel_i,
  // lines 0..7
  input  wire logic [`PBL_LO_W-1:0]   lo_lines_i,
  output logic      [`PBL_LO_W-1:0]   lo_lines_o,
  output logic      [`PBL_LO_W-1:0]   lo_lines_oe_o,
  // shared_bit8_lane_pin
  input  wire logic                   shared_bit8_lane_pin_i,
  output logic                        shared_bit8_lane_pin_o,
  output logic                        shared_bit8_lane_pin_oe_o,
  // lines 9..11
  input  wire logic [`PBL_HI_W-1:0]   hi_lines_i,
  output logic      [`PBL_HI_W-1:0]   hi_lines_o,
  output logic      [`PBL_HI_W-1:0]   hi_lines_oe_o,
  // core side: result to present
  input  wire logic [`PBL_WORD_W-1:0] result_i,
  input  wire logic [`PBL_CHAN_W-1:0] result_chan_i,
  // core side: register write pulse and read done pulse
  output logic                        wr_strobe_o,
  output logic      [`PBL_WORD_W-1:0] wr_data_o,
  output logic      [1:0]             wr_lane_o,
  output logic                        rd_done_o
);

  ////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers

  logic         rst_m_q;   // first reset stage
  logic         rst_s_q;   // released reset used everywhere
  pbl_pins_type pin_raw;   // pins as they arrive
  pbl_pins_type pin_m_q;   // first stage, read only by second
  pbl_pins_type pin_q;     // safe copy

  assign pin_raw = '{cs_n: cs_n_i, rd_n: rd_n_i, wr_n: wr_n_i, word_sel: word_sel_i,
                     shared: shared_bit8_lane_pin_i, lo: lo_lines_i, hi: hi_lines_i};

  // reset: assert at once, release after two edges
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end

  // strobes idle high so a reset never looks like an access
  always_ff @(posedge mclk_i or negedge rst_s_q) begin
    if (!rst_s_q) begin
      pin_m_q <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
      pin_q   <= '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
    end else begin
      pin_m_q <= pin_raw;
      pin_q   <= pin_m_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode of the sampled pins

  wire rd_act = !pin_q.cs_n && !pin_q.rd_n; // read in progress
  wire wr_act = !pin_q.cs_n && !pin_q.wr_n; // write in progress
  wire high_byte_enable = !pin_q.word_sel && pin_q.shared; // shared pin as lane pick

  ////////////////////////////////////////////////////////////////////////////
  // bus phase

  pbl_state_type st_q;
  pbl_state_type st_d;

  // a strobe pair wins only from idle; the other strobe is ignored until release
  always_comb begin
    st_d = st_q;
    case (st_q)
      PBL_IDLE: begin
        if (rd_act) begin
          st_d = PBL_READ;
        end else if (wr_act) begin
          st_d = PBL_WRIT;
        end
      end
      PBL_READ: begin
        if (!rd_act) begin
          st_d = PBL_IDLE;
        end
      end
      PBL_WRIT: begin
        if (!wr_act) begin
          st_d = PBL_IDLE;
        end
      end
      default: st_d = PBL_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // read snapshot: taken at the start so the bus holds still all read long

  pbl_rdlat_type lat_q;
  pbl_rdlat_type lat_d;
  wire           rd_start = (st_q == PBL_IDLE) && (st_d == PBL_READ);
  wire           rd_on    = (st_d == PBL_READ);

  assign lat_d = rd_start ? '{res: result_i, chan: result_chan_i,
                              word: pin_q.word_sel, high_byte_enable: high_byte_enable} : lat_q;

  // lane mux for the next pin values
  wire byte_hi = rd_on && !lat_d.word && lat_d.high_byte_enable;
  wire [`PBL_LO_W-1:0] hi_byte = {1'b0, lat_d.chan,
                                  lat_d.res[`PBL_UPPER_MSB:`PBL_UPPER_LSB]};
  wire [`PBL_LO_W-1:0] lo_d    = byte_hi ? hi_byte : lat_d.res[`PBL_LO_W-1:0];
  wire [`PBL_LO_W-1:0] lo_oe_d = rd_on ? 8'hff : 8'h00;
  wire                 sh_oe_d = rd_on && lat_d.word;
  wire [`PBL_HI_W-1:0] hi_oe_d = (rd_on && lat_d.word) ? 3'h7 : 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // write capture: lines sampled together with the strobe rise

  wire wr_end = (st_q == PBL_WRIT) && !wr_act;
  // host zero-fills the top of a high write; those lines are not used here
  wire [`PBL_WORD_W-1:0] wdat_d =
    pin_q.word_sel   ? {pin_q.hi, pin_q.shared, pin_q.lo} :
    high_byte_enable ? {pin_q.lo[`PBL_NIB_MSB:0], `PBL_LO_RST} :
                       {4'h0, pin_q.lo};
  wire [1:0] lane_d = pin_q.word_sel   ? `PBL_LANE_WORD :
                      high_byte_enable ? `PBL_LANE_HI : `PBL_LANE_LO;

  ////////////////////////////////////////////////////////////////////////////
  // registers and registered outputs

  // everything on the pins and core side comes out of flops
  always_ff @(posedge mclk_i or negedge rst_s_q) begin
    if (!rst_s_q) begin
      st_q                      <= PBL_IDLE;
      lat_q                     <= '0;
      lo_lines_o                <= `PBL_LO_RST;
      lo_lines_oe_o             <= `PBL_LO_RST;
      shared_bit8_lane_pin_o    <= 1'b0;
      shared_bit8_lane_pin_oe_o <= 1'b0;
      hi_lines_o                <= `PBL_HI_RST;
      hi_lines_oe_o             <= `PBL_HI_RST;
      wr_strobe_o               <= 1'b0;
      wr_data_o                 <= `PBL_WORD_RST;
      wr_lane_o                 <= `PBL_LANE_RST;
      rd_done_o                 <= 1'b0;
    end else begin
      st_q                      <= st_d;
      lat_q                     <= lat_d;
      lo_lines_o                <= lo_d;
      lo_lines_oe_o             <= lo_oe_d;
      shared_bit8_lane_pin_o    <= lat_d.res[`PBL_SHARED_BIT];
      shared_bit8_lane_pin_oe_o <= sh_oe_d;
      hi_lines_o                <= lat_d.res[`PBL_HI_MSB:`PBL_HI_LSB];
      hi_lines_oe_o             <= hi_oe_d;
      wr_strobe_o               <= wr_end;
      rd_done_o                 <= (st_q == PBL_READ) && !rd_act;
      if (wr_end) begin
        wr_data_o <= wdat_d;
        wr_lane_o <= lane_d;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_s_q);

  read_drive_a: assert property (rd_act && st_q == PBL_IDLE |=> lo_lines_oe_o == 8'hff)
    else $error("read strobe did not drive the low lines");
  float_idle_a: assert property (st_q != PBL_READ |-> lo_lines_oe_o == 8'h00
      && !shared_bit8_lane_pin_oe_o && hi_lines_oe_o == 3'h0)
    else $error("bus driven outside a read");
  low_lines_a: assert property (st_q == PBL_READ |->
      lo_lines_oe_o == 8'hff)
    else $error("low line enables wrong during read");
  bit8_word_a: assert property (st_q == PBL_READ && lat_q.word |->
      shared_bit8_lane_pin_oe_o && shared_bit8_lane_pin_o == lat_q.res[8])
    else $error("bit 8 not presented in word mode");
  lane_in_a: assert property (!pin_q.word_sel && st_q == PBL_IDLE |=>
      !shared_bit8_lane_pin_oe_o)
    else $error("shared pin driven in byte mode");
  low_byte_a: assert property (st_q == PBL_READ && !lat_q.word
      && !lat_q.high_byte_enable |-> lo_lines_o == lat_q.res[7:0])
    else $error("low byte lane wrong");
  high_nib_a: assert property (st_q == PBL_READ && !lat_q.word
      && lat_q.high_byte_enable |-> lo_lines_o[3:0] == lat_q.res[11:8] && !lo_lines_o[7])
    else $error("upper nibble lane wrong");
  chan_tag_a: assert property (st_q == PBL_READ && !lat_q.word
      && lat_q.high_byte_enable |-> lo_lines_o[6:4] == lat_q.chan)
    else $error("channel tag missing on high byte");
  upper_word_a: assert property (st_q == PBL_READ && lat_q.word |->
      hi_lines_oe_o == 3'h7 && hi_lines_o == lat_q.res[11:9])
    else $error("upper lines wrong in word mode");
  write_pulse_a: assert property (st_q == PBL_WRIT && (pin_q.wr_n || pin_q.cs_n) |=>
      wr_strobe_o ##1 !wr_strobe_o)
    else $error("write pulse not one cycle after strobe release");

endmodule

// File: pbl_cfg.svh
// pbl_cfg.svh - constants for the converter's parallel host bus port.
// assumes: included by the package and the port module, by bare name.
`ifndef PBL_CFG_SVH
`define PBL_CFG_SVH

// widths of the lanes and the result
`define PBL_WORD_W      12
`define PBL_LO_W        8
`define PBL_HI_W        3
`define PBL_CHAN_W      3

// field positions inside the twelve-bit word
`define PBL_SHARED_BIT  8
`define PBL_HI_LSB      9
`define PBL_HI_MSB      11
`define PBL_UPPER_LSB   8
`define PBL_UPPER_MSB   11

// field positions inside the high byte on the lower lines
`define PBL_NIB_MSB     3
`define PBL_TAG_LSB     4
`define PBL_TAG_MSB     6
`define PBL_TOP_BIT     7

// lane masks on a write pulse
`define PBL_LANE_LO     2'h1
`define PBL_LANE_HI     2'h2
`define PBL_LANE_WORD   2'h3

// reset values
`define PBL_WORD_RST    12'h000
`define PBL_LO_RST      8'h00
`define PBL_HI_RST      3'h0
`define PBL_CHAN_RST    3'h0
`define PBL_LANE_RST    2'h0

`endif

// File: pbl_pkg.sv
// pbl_pkg.sv - types shared by the parallel host bus port.
// assumes: pbl_cfg.svh sits in the same folder.
`include "pbl_cfg.svh"

package pbl_pkg;

  // one sampled snapshot of every host-facing input pin
  typedef struct packed {
    logic                  cs_n;     // device select
    logic                  rd_n;     // read strobe
    logic                  wr_n;     // write strobe
    logic                  word_sel; // high = word mode, low = byte mode
    logic                  shared;   // bit 8 or high_byte_enable
    logic [`PBL_LO_W-1:0]  lo;       // lines 0..7
    logic [`PBL_HI_W-1:0]  hi;       // lines 9..11
  } pbl_pins_type;

  // read-side snapshot: result, its channel and lane choice
  typedef struct packed {
    logic [`PBL_WORD_W-1:0] res;
    logic [`PBL_CHAN_W-1:0] chan;
    logic                   word;
    logic                   high_byte_enable; // lane pick taken at read start
  } pbl_rdlat_type;

  // bus phase, one-hot
  typedef enum logic [2:0] {
    PBL_IDLE = 3'b001,
    PBL_READ = 3'b010,
    PBL_WRIT = 3'b100
  } pbl_state_type;

endpackage

// File: pbl_host.sv
// pbl_host.sv - behavioural host processor on the parallel bus pins.
// assumes: device enables are high while it drives; the bench calls the tasks.
module pbl_host (
  // clock
  input  wire logic        mclk_i,
  // device drive and enables, lines 11..0
  input  wire logic [11:0] dev_i,
  input  wire logic [11:0] dev_oe_i,
  // resolved pin levels and host strobes
  output logic      [11:0] pin_o,
  output logic             cs_n_o,
  output logic             rd_n_o,
  output logic             wr_n_o,
  output logic             word_sel_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] drv_q = 12'h000;           // value the host puts on the lines
  logic        own_q = 1'b0;              // host drives the data lines
  logic        high_byte_enable_q = 1'b0; // lane choice in byte mode
  logic        tog_q = 1'b0;              // released lines toggle, never stale
  initial {cs_n_o, rd_n_o, wr_n_o, word_sel_o} = 4'hf;
  always @(posedge mclk_i) tog_q <= ~tog_q;
  ////////////////////////////////////////////////////////////////////////////
  // wire level from both enables; bit 8 is the lane input in byte mode
  always_comb begin
    for (int b = 0; b < 12; b++) begin
      pin_o[b] = dev_oe_i[b] ? dev_i[b] : (b == 8 && !word_sel_o) ? high_byte_enable_q
               : (own_q && (b < 8 || word_sel_o)) ? drv_q[b] : tog_q;
    end
  end
  // open an access: lane setup, then select and one strobe together
  task automatic begin_acc(input logic rd, word, upper, input logic [11:0] d);
    @(negedge mclk_i);
    word_sel_o = word;
    high_byte_enable_q = upper;
    drv_q = (!word && upper) ? {d[11:8], 4'h0, d[3:0]} : d;
    own_q = !rd;
    cs_n_o = 1'b0;
    rd_n_o = !rd;
    wr_n_o = rd;
  endtask
  // close it: strobes up, write data held two more cycles
  task automatic end_acc();
    @(negedge mclk_i);
    {cs_n_o, rd_n_o, wr_n_o} = 3'h7;
    repeat (2) @(negedge mclk_i);
    own_q = 1'b0;
  endtask
endmodule

// File: pbl_tb.sv
// pbl_tb.sv - self-checking bench for the parallel host bus port.
// assumes: pbl_host.sv models the host; the bench supplies result and tag.
module adc_parallel_bus_lane_mapping_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk_i = 1'b0;  // 100 MHz clock
  logic        rst_n_i = 1'b0; // async reset
  logic [11:0] res = 12'h000;  // result offered to the port
  logic [2:0]  chan = 3'h0;    // its channel tag
  wire  [11:0] pin;            // resolved lines 11..0
  wire  [11:0] dev_o;          // device drive
  wire  [11:0] dev_oe;         // device enables
  wire         cs_n, rd_n, wr_n, wsel;
  logic [11:0] wr_data;        // written word seen by the core
  logic [1:0]  wr_lane;
  logic        wr_strobe, rd_done;
  int          n_mismatch = 0, comparisons = 0, seed = 32'hcbe7;
  always #5 mclk_i = ~mclk_i;
  ////////////////////////////////////////////////////////////////////////////
  pbl_host pbl_host_i (.mclk_i(mclk_i), .dev_i(dev_o), .dev_oe_i(dev_oe), .pin_o(pin),
    .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n), .word_sel_o(wsel));
  pbl_port pbl_port_i (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n),
    .word_sel_i(wsel), .lo_lines_i(pin[7:0]), .lo_lines_o(dev_o[7:0]),
    .lo_lines_oe_o(dev_oe[7:0]), .shared_bit8_lane_pin_i(pin[8]),
    .shared_bit8_lane_pin_o(dev_o[8]), .shared_bit8_lane_pin_oe_o(dev_oe[8]),
    .hi_lines_i(pin[11:9]), .hi_lines_o(dev_o[11:9]), .hi_lines_oe_o(dev_oe[11:9]),
    .result_i(res), .result_chan_i(chan), .wr_strobe_o(wr_strobe), .wr_data_o(wr_data),
    .wr_lane_o(wr_lane), .rd_done_o(rd_done));
  ////////////////////////////////////////////////////////////////////////////
  // one compare for every kind of result
  task automatic check(input string what, input logic [11:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // bounded wait for the completion pulse of a read or a write
  task automatic wait_done(input logic wr);
    for (int i = 0; i < 12 && (wr ? wr_strobe : rd_done) !== 1'b1; i++) @(posedge mclk_i) #1;
    check("done pulse", 12'h001, {11'h000, wr ? wr_strobe : rd_done});
  endtask
  // read: lanes and enables, late result change ignored, then release
  task automatic do_read(input logic word, upper);
    logic [11:0] m, e;
    m = word ? 12'hfff : 12'h0ff;
    pbl_host_i.begin_acc(1'b1, word, upper, 12'h000);
    res = 12'($random(seed));
    chan = 3'($random(seed));
    e = word ? res : upper ? {5'h00, chan, res[11:8]} : {4'h0, res[7:0]};
    repeat (4) @(negedge mclk_i);
    res = ~res;
    chan = ~chan;
    @(posedge mclk_i) #1;
    check("read enables", m, dev_oe);
    check("read lines", e, pin & m);
    pbl_host_i.end_acc();
    wait_done(1'b0);
    check("released", 12'h000, dev_oe);
  endtask
  // write: lines stay floating, then word and lane reach the core
  task automatic do_write(input logic word, upper);
    logic [11:0] d, e;
    d = 12'($random(seed));
    pbl_host_i.begin_acc(1'b0, word, upper, d);
    repeat (4) @(posedge mclk_i) #1;
    check("write enables", 12'h000, dev_oe);
    pbl_host_i.end_acc();
    wait_done(1'b1);
    e = word ? d : upper ? {d[3:0], 8'h00} : {4'h0, d[7:0]};
    check("write data", e, wr_data);
    check("write lane", {10'h0, word ? 2'h3 : upper ? 2'h2 : 2'h1}, {10'h0, wr_lane});
  endtask
  // counts, verdict, end of run
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // six hand cases cover every mode and lane, then random back-to-back mix
  initial begin
    logic [2:0] k;
    repeat (2) @(negedge mclk_i);
    check("reset enables", 12'h000, dev_oe);
    rst_n_i = 1'b1;
    repeat (4) @(negedge mclk_i);
    for (int i = 0; i < 40; i++) begin
      k = (i < 6) ? 3'(i) : 3'($random(seed));
      if (k[0]) do_write(k[2], k[1]);
      else do_read(k[2], k[1]);
    end
    report_and_stop();
  end
  // watchdog: the run needs about 3 us
  initial begin
    #20us;
    n_mismatch++;
    report_and_stop();
  end
endmodule
